// ### logic/pcs_pkg.sv
// What this block does
// - software handshakes before gating these three clocks
// - peripheral finishes transfers before granting stop
// - set request, poll grant, then gate
// - ungate clock first, then clear request
// - bit 5 read-only serial port grant
// - bit 4 serial port request; gate register one
// - bit 3 read-only usb grant
// - bit 2 usb request; gate register two
// - bit 1 read-only external memory grant
// - bit 0 external memory request; gate register one
// - grant zero pending, one safe to gate
// - request zero normal, one asks stop
// - reset: requests and grants one, 15-6 zero
// - gate bit zero runs clock, one stops
package pcs_pkg;

    // peripheral index inside every three-bit vector
    localparam int PCS_EXT_MEMORY = 0;
    localparam int PCS_USB        = 1;
    localparam int PCS_SERIAL     = 2;
    localparam int PCS_NUM_PERIPH = 3;

    // i/o register space
    localparam logic [15:0] PCS_ADDR_HANDSHAKE = 16'h1c3a;
    localparam logic [15:0] PCS_ADDR_GATE_ONE  = 16'h1c02;
    localparam logic [15:0] PCS_ADDR_GATE_TWO  = 16'h1c03;

    // handshake register field positions
    localparam int PCS_BIT_EXT_MEMORY_REQ   = 0;
    localparam int PCS_BIT_EXT_MEMORY_GRANT = 1;
    localparam int PCS_BIT_USB_REQ          = 2;
    localparam int PCS_BIT_USB_GRANT        = 3;
    localparam int PCS_BIT_SERIAL_REQ       = 4;
    localparam int PCS_BIT_SERIAL_GRANT     = 5;

    // gate bit positions in the two gating registers
    localparam int PCS_GATE_ONE_EXT_MEMORY = 1;
    localparam int PCS_GATE_ONE_SERIAL     = 5;
    localparam int PCS_GATE_TWO_USB        = 2;

    // writable bits of the gating registers; others read zero
    localparam logic [15:0] PCS_GATE_ONE_MASK = 16'hffff;
    localparam logic [15:0] PCS_GATE_TWO_MASK = 16'h007f;

    // reset values
    localparam logic [2:0]  PCS_RST_REQ      = 3'h7;
    localparam logic [2:0]  PCS_RST_GRANT    = 3'h7;
    localparam logic [15:0] PCS_RST_GATE_ONE = 16'h0000;
    localparam logic [15:0] PCS_RST_GATE_TWO = 16'h0000;

    typedef struct packed {
        logic [2:0]  req;
        logic [2:0]  grant;
        logic [15:0] gate_one;
        logic [15:0] gate_two;
        logic [2:0]  clk_run;
        logic [15:0] rdata;
        logic        rvalid;
        logic        miss;
        logic        gate_fault;
    } pcs_reg_state_t;

    localparam pcs_reg_state_t PCS_REG_RST = '{
        req:        PCS_RST_REQ,
        grant:      PCS_RST_GRANT,
        gate_one:   PCS_RST_GATE_ONE,
        gate_two:   PCS_RST_GATE_TWO,
        clk_run:    3'h7,
        rdata:      16'h0000,
        rvalid:     1'b0,
        miss:       1'b0,
        gate_fault: 1'b0
    };

    typedef struct packed {
        logic [2:0] grant;
        logic [2:0] hold_new;
    } pcs_periph_state_t;

    localparam pcs_periph_state_t PCS_PERIPH_RST = '{
        grant:    PCS_RST_GRANT,
        hold_new: PCS_RST_REQ
    };

endpackage

// ### logic/pcs_link_if.sv
`timescale 1ns/1ps
interface pcs_link_if;
    logic [2:0] stop_req;  // register to peripherals, one per peripheral
    logic [2:0] grant;     // peripherals to register
    logic [2:0] clk_run;   // high while the gate bit lets the clock run

    modport reg_end (
        output stop_req,
        output clk_run,
        input  grant
    );

    modport periph_end (
        input  stop_req,
        input  clk_run,
        output grant
    );
endinterface

// ### logic/pcs_periph_end.sv
`timescale 1ns/1ps
module pcs_periph_end
    import pcs_pkg::*;
(
    input  wire logic       clk,       // system clock
    input  wire logic       sys_rst,   // synchronous reset, high
    pcs_link_if.periph_end  link,      // handshake link
    input  wire logic [2:0] busy,      // transfer in progress, per core
    output logic      [2:0] hold_new,  // core must start no new transfer
    output logic      [2:0] granted    // copy of grant for the cores
);

    pcs_periph_state_t r;
    pcs_periph_state_t next_r;

    always_comb begin
        next_r = r;
        // cores see the request one cycle before a grant can rise
        next_r.hold_new = link.stop_req;
        for (int i = 0; i < PCS_NUM_PERIPH; i++) begin
            if (link.stop_req[i] && r.hold_new[i] && !busy[i]) begin
                next_r.grant[i] = 1'b1;
            end else if (!link.stop_req[i] && link.clk_run[i]) begin
                // a grant left high while gated keeps the core frozen
                next_r.grant[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= PCS_PERIPH_RST;
        end else begin
            r <= next_r;
        end
    end

    assign link.grant = r.grant;
    assign hold_new   = r.hold_new;
    assign granted    = r.grant;

endmodule

// ### logic/pcs_handshake_reg.sv
`timescale 1ns/1ps
module pcs_handshake_reg
    import pcs_pkg::*;
(
    input  wire logic        clk,         // system clock
    input  wire logic        sys_rst,     // synchronous reset, high
    input  wire logic [15:0] io_addr,     // i/o word address
    input  wire logic        io_wr,       // write strobe
    input  wire logic        io_rd,       // read strobe
    input  wire logic [15:0] io_wdata,    // write data
    output logic      [15:0] io_rdata,    // read data, valid with rvalid
    output logic             io_rvalid,   // read answer, one cycle
    output logic             io_miss,     // unmapped access, one cycle
    output logic             gate_fault,  // clock gated without grant
    pcs_link_if.reg_end      link         // handshake link
);

    pcs_reg_state_t r;
    pcs_reg_state_t next_r;

    function automatic logic is_reg(input logic [15:0] a);
        is_reg = (a == PCS_ADDR_HANDSHAKE) || (a == PCS_ADDR_GATE_ONE)
              || (a == PCS_ADDR_GATE_TWO);
    endfunction

    // gate bits collected into peripheral order
    function automatic logic [2:0] gate_vec(input logic [15:0] one,
                                            input logic [15:0] two);
        gate_vec[PCS_EXT_MEMORY] = one[PCS_GATE_ONE_EXT_MEMORY];
        gate_vec[PCS_USB]        = two[PCS_GATE_TWO_USB];
        gate_vec[PCS_SERIAL]     = one[PCS_GATE_ONE_SERIAL];
    endfunction

    function automatic logic [15:0] handshake_word(input logic [2:0] req,
                                                   input logic [2:0] gnt);
        handshake_word = 16'h0000;
        handshake_word[PCS_BIT_EXT_MEMORY_REQ]   = req[PCS_EXT_MEMORY];
        handshake_word[PCS_BIT_EXT_MEMORY_GRANT] = gnt[PCS_EXT_MEMORY];
        handshake_word[PCS_BIT_USB_REQ]          = req[PCS_USB];
        handshake_word[PCS_BIT_USB_GRANT]        = gnt[PCS_USB];
        handshake_word[PCS_BIT_SERIAL_REQ]       = req[PCS_SERIAL];
        handshake_word[PCS_BIT_SERIAL_GRANT]     = gnt[PCS_SERIAL];
    endfunction

    always_comb begin
        logic [2:0] old_gate;
        logic [2:0] new_gate;
        old_gate = 3'h0;
        new_gate = 3'h0;
        next_r = r;
        next_r.rvalid = 1'b0;
        next_r.miss = 1'b0;
        next_r.gate_fault = 1'b0;

        // grants are only ever mirrored; writes cannot touch them
        next_r.grant = link.grant;

        if (io_wr) begin
            case (io_addr)
                PCS_ADDR_HANDSHAKE: begin
                    next_r.req[PCS_EXT_MEMORY] =
                        io_wdata[PCS_BIT_EXT_MEMORY_REQ];
                    next_r.req[PCS_USB] =
                        io_wdata[PCS_BIT_USB_REQ];
                    next_r.req[PCS_SERIAL] =
                        io_wdata[PCS_BIT_SERIAL_REQ];
                end
                PCS_ADDR_GATE_ONE: begin
                    next_r.gate_one = io_wdata & PCS_GATE_ONE_MASK;
                end
                PCS_ADDR_GATE_TWO: begin
                    next_r.gate_two = io_wdata & PCS_GATE_TWO_MASK;
                end
                default: begin
                    next_r.miss = 1'b1;
                end
            endcase
        end

        // clock enable follows gate bits: zero runs, one stops
        old_gate = gate_vec(r.gate_one, r.gate_two);
        new_gate = gate_vec(next_r.gate_one, next_r.gate_two);
        next_r.clk_run = ~new_gate;

        // flag software that stops a clock it was not granted;
        // the gate still takes effect, the flag is diagnostic only
        if (|(new_gate & ~old_gate & ~r.grant)) begin
            next_r.gate_fault = 1'b1;
        end

        if (io_rd) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = 16'h0000;
            if (!is_reg(io_addr)) begin
                next_r.miss = 1'b1;
            end
            case (io_addr)
                PCS_ADDR_HANDSHAKE: begin
                    // read returns values held before a same-cycle write
                    next_r.rdata = handshake_word(r.req, r.grant);
                end
                PCS_ADDR_GATE_ONE: begin
                    next_r.rdata = r.gate_one;
                end
                PCS_ADDR_GATE_TWO: begin
                    next_r.rdata = r.gate_two;
                end
                default: begin
                    next_r.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= PCS_REG_RST;
        end else begin
            r <= next_r;
        end
    end

    assign io_rdata      = r.rdata;
    assign io_rvalid     = r.rvalid;
    assign io_miss       = r.miss;
    assign gate_fault    = r.gate_fault;
    assign link.stop_req = r.req;
    assign link.clk_run  = r.clk_run;

endmodule

// ### verification/pcs_link_sva.sv
`timescale 1ns/1ps
module pcs_link_sva (
    input wire logic       clk,       // system clock
    input wire logic       sys_rst,   // synchronous reset, high
    input wire logic [2:0] stop_req,  // stop asked, per peripheral
    input wire logic [2:0] grant,     // stop granted, per peripheral
    input wire logic [2:0] clk_run    // clock running, per peripheral
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_reset_vals: assert property ($fell(sys_rst) |->
        (stop_req & grant & clk_run) == 3'h7) else $error("not reset");
    a_rise_now: assert property (
        (grant & ~$past(grant) & ~$past(stop_req)) == 3'h0)
        else $error("grant rose unasked");
    a_rise_held: assert property (
        (grant & ~$past(grant) & ~$past(stop_req, 2)) == 3'h0)
        else $error("grant rose too early");
    a_fall_cause: assert property (
        ($past(grant) & ~grant & ~$past(~stop_req & clk_run)) == 3'h0)
        else $error("grant fell without cause");
    a_drop_prompt: assert property (
        ($past(grant & ~stop_req & clk_run) & grant) == 3'h0)
        else $error("grant not dropped");
    a_gated_hold: assert property (
        ($past(grant & ~clk_run) & ~grant) == 3'h0)
        else $error("grant fell while gated");
    a_req_hold: assert property (
        ($past(grant & stop_req) & ~grant) == 3'h0)
        else $error("grant fell while asked");
    a_fall_gap: assert property ($fell(grant[1]) |=> !grant[1])
        else $error("grant bounced");
    c_rise: cover property ($rose(grant[0]));
    c_gated: cover property (grant[1] && !clk_run[1]);
    c_fall: cover property ($fell(grant[2]));
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import pcs_pkg::*;
;
    logic        clk      = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [15:0] io_addr  = 16'h0000;
    logic        io_wr    = 1'b0;
    logic        io_rd    = 1'b0;
    logic [15:0] io_wdata = 16'h0000;
    logic [2:0]  busy     = 3'h0;
    logic [15:0] io_rdata;
    logic        io_rvalid;
    logic        io_miss;
    logic        gate_fault;
    logic [2:0]  hold_new;
    logic        seen_miss  = 1'b0;
    logic        seen_fault = 1'b0;
    int          errors   = 0;
    int          checks   = 0;
    pcs_link_if link ();
    pcs_handshake_reg u_pcs_handshake_reg (.clk(clk), .sys_rst(sys_rst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .io_miss(io_miss), .gate_fault(gate_fault), .link(link));
    pcs_periph_end u_pcs_periph_end (.clk(clk), .sys_rst(sys_rst),
        .link(link), .busy(busy), .hold_new(hold_new), .granted());
    pcs_link_sva u_pcs_link_sva (.clk(clk), .sys_rst(sys_rst),
        .stop_req(link.stop_req), .grant(link.grant),
        .clk_run(link.clk_run));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // all bus tasks start and end just after a rising edge
    // the one-cycle pulses are caught while they stand; the spare cycle
    // keeps a strobe from being lowered and raised in one time step
    task automatic wr(input logic [15:0] a, d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk);
        #1 io_wr = 1'b0;
        seen_miss = io_miss;
        seen_fault = gate_fault;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [15:0] a, e, input string n);
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk);
        #1 io_rd = 1'b0;
        chk("rvalid", {15'h0, io_rvalid}, 16'h0001);
        chk(n, io_rdata, e);
        @(posedge clk);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        rd(PCS_ADDR_HANDSHAKE, 16'h003f, "hs");
        rd(PCS_ADDR_GATE_TWO, 16'h0000, "g2");
        wr(16'h0000, 16'hffff);
        chk("miss", {15'h0, seen_miss}, 16'h0001);
        $display("t_reset done");
    endtask
    task automatic t_ext;
        wr(PCS_ADDR_HANDSHAKE, 16'h0000);
        idle(4);
        rd(PCS_ADDR_HANDSHAKE, 16'h0000, "hs idle");
        busy = 3'h1;
        wr(PCS_ADDR_HANDSHAKE, 16'h0001);
        idle(6);
        chk("hold", {13'h0, hold_new}, 16'h0001);
        rd(PCS_ADDR_HANDSHAKE, 16'h0001, "hs busy");
        busy = 3'h0;
        idle(4);
        rd(PCS_ADDR_HANDSHAKE, 16'h0003, "hs ext");
        wr(PCS_ADDR_GATE_ONE, 16'h0002);
        chk("fault", {15'h0, seen_fault}, 16'h0000);
        chk("run", {13'h0, link.clk_run}, 16'h0006);
        // grant and reserved bits must ignore the write
        wr(PCS_ADDR_HANDSHAKE, 16'hffe2);
        idle(4);
        rd(PCS_ADDR_HANDSHAKE, 16'h0002, "hs gated");
        wr(PCS_ADDR_GATE_ONE, 16'h0000);
        idle(4);
        rd(PCS_ADDR_HANDSHAKE, 16'h0000, "hs back");
        $display("t_ext done");
    endtask
    task automatic t_pair;
        wr(PCS_ADDR_HANDSHAKE, 16'h0014);
        idle(4);
        rd(PCS_ADDR_HANDSHAKE, 16'h003c, "hs pair");
        wr(PCS_ADDR_GATE_TWO, 16'h0004);
        wr(PCS_ADDR_GATE_ONE, 16'h0020);
        chk("run", {13'h0, link.clk_run}, 16'h0001);
        wr(PCS_ADDR_GATE_ONE, 16'h0022);
        chk("fault", {15'h0, seen_fault}, 16'h0001);
        wr(PCS_ADDR_GATE_TWO, 16'h0000);
        wr(PCS_ADDR_GATE_ONE, 16'h0000);
        wr(PCS_ADDR_HANDSHAKE, 16'h0000);
        idle(4);
        rd(PCS_ADDR_HANDSHAKE, 16'h0000, "hs off");
        $display("t_pair done");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_ext();
        t_pair();
        close_out();
    end
    // the tests need about 80 cycles; the limit allows 2000
    initial begin
        #200000;
        errors++;
        close_out();
    end
endmodule
